/* verilog/srsb_pkg.sv */
/*
 refresh side-band package: constants and carrier types.
 assumes one controller clock, synchronous active-high reset.
*/
`default_nettype none
package srsb_pkg;
	localparam int SRSB_NUM_RANKS     = 4;
	localparam int SRSB_ROW_BITS      = 13;
	localparam int SRSB_BANK_BITS     = 2;
	localparam int SRSB_COL_BITS      = 10;
	localparam int SRSB_RATE_DROP     = 1;
	localparam int SRSB_ADDR_W        = SRSB_ROW_BITS + SRSB_BANK_BITS + SRSB_COL_BITS
		- SRSB_RATE_DROP;
	localparam int SRSB_MAX_BURST     = 9;
	localparam int SRSB_REFRESH_CYC   = 4;
	localparam int SRSB_SELF_CYC      = 4;
	localparam int SRSB_SYNC_STAGES   = 2;
	localparam logic [3:0] SRSB_CNT_RST = 4'h0;

	typedef struct packed {
		logic [SRSB_ROW_BITS-1:0]  row;
		logic [SRSB_BANK_BITS-1:0] bank;
		logic [SRSB_COL_BITS-1:0]  col;
	} srsb_mem_addr_t;

	typedef struct packed {
		logic                      req;
		logic [SRSB_NUM_RANKS-1:0] chip;
	} srsb_refresh_req_t;

	typedef enum logic [2:0] {
		SRSB_IDLE,
		SRSB_REFRESH,
		SRSB_SELF_ENTER,
		SRSB_SELF_HOLD,
		SRSB_SELF_EXIT
	} srsb_state_t;
endpackage : srsb_pkg
`default_nettype wire

/* verilog/srsb_ctrl.sv */
/*
 refresh and side-band control: user refresh handshake, self-refresh,
 reset generation, half-rate aux clock, address split, queue hold-off.
 assumes user logic on clk_sys, refresh chip-select driven with request.
*/
// Contract
// R1: self-refresh acknowledge rises once any rank has entered self-refresh.
// R2: refresh request takes precedence over queued reads and writes.
// R3: user drives refresh chip select together with the request.
// R4: held request keeps producing further refresh operations.
// R5: user drops request after desired count of acknowledges.
// R6: user requests at most nine back-to-back refreshes per burst.
// R7: user never targets one rank with self and user refresh together.
// R8: refresh request, chip select, acknowledge all on controller clock.
// R9: configuration port is a removable 32-bit slave, fixed address width.
// R10: configuration port clock equals controller clock.
// R11: command channel one beat; data channels many beats, read carries error.
// R12: global reset asynchronous; internal resets from resynchronised copies.
// R13: user-side signals synchronous to system clock.
// R14: user reset output asserts asynchronously, releases synchronously.
// R15: full-rate aux clock runs at memory interface frequency. This block has no full-rate aux clock output.
// R16: half-rate aux clock runs at half memory interface frequency.
// R17: reset request stays low while pll unlocked; act on falling edge.
// R18: soft reset edge resets physical layer, pll keeps running.
// R19: user holds burst address stable only during first transfer.
// R20: address split uses bank interleaving by default, option may change.
// R21: full-rate single-rank address width is row+bank+column minus one.
// R22: self-refresh ack follows entry, clears after exit when request drops.
// R23: each refresh chip-select bit selects one rank, active high.
// R24: acknowledge pulses one cycle per refresh issued.
`timescale 1ns/1ns
`default_nettype none
module srsb_ctrl
	import srsb_pkg::*;
#(
	parameter int NUM_RANKS   = SRSB_NUM_RANKS,
	parameter bit ROW_FIRST   = 1'b0
)(
	// clock, reset, enable
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    clk_en,
	input  wire logic                    global_reset_n,
	input  wire logic                    soft_reset_n,
	input  wire logic                    pll_locked,
	// user refresh
	input  wire srsb_refresh_req_t       user_refresh,
	output logic                         refresh_ack,
	output logic [NUM_RANKS-1:0]         refresh_ranks,
	// self refresh
	input  wire logic                    self_req,
	input  wire logic [NUM_RANKS-1:0]    self_chip,
	output logic                         self_ack,
	// queue and address
	output logic                         queue_hold,
	input  wire logic [SRSB_ADDR_W-1:0]  local_addr,
	output srsb_mem_addr_t               mem_addr,
	// resets and half-rate aux clock
	output logic                         user_reset_n,
	output logic                         phy_reset_n,
	output logic                         reset_request_n,
	output logic                         aux_half_rate_clk
);
	srsb_state_t                 state_q, state_d;
	logic [3:0]                  cnt_q, cnt_d;
	logic                        ack_q, ack_d;
	logic                        sack_q, sack_d;
	logic [NUM_RANKS-1:0]        ranks_q, ranks_d;
	logic [SRSB_SYNC_STAGES-1:0] grst_q;
	logic [SRSB_SYNC_STAGES-1:0] urst_q;
	logic                        soft_q, soft_d;
	logic                        phy_q, phy_d;
	logic                        half_q;
	srsb_mem_addr_t              addr_d;

	// R8 R13 R23 refresh sequencer
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		ack_d   = 1'b0;
		sack_d  = sack_q;
		ranks_d = ranks_q;
		unique case (state_q)
			SRSB_IDLE:
			begin
				// R4 retake after ack seen
				// R2 refresh first
				if (!ack_q && user_refresh.req && |user_refresh.chip)
				begin
					state_d = SRSB_REFRESH;
					ranks_d = user_refresh.chip;
					cnt_d   = 4'(SRSB_REFRESH_CYC - 1);
				end
				else if (!ack_q && self_req && |self_chip)
				begin
					state_d = SRSB_SELF_ENTER;
					ranks_d = self_chip;
					cnt_d   = 4'(SRSB_SELF_CYC - 1);
				end
			end
			SRSB_REFRESH:
			begin
				if (cnt_q == SRSB_CNT_RST)
				begin
					// R24 one pulse per refresh
					ack_d = 1'b1;
					// R4 held request repeats
					state_d = SRSB_IDLE;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			SRSB_SELF_ENTER:
			begin
				if (cnt_q == SRSB_CNT_RST)
				begin
					// R1 first rank entered
					sack_d  = 1'b1;
					state_d = SRSB_SELF_HOLD;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			SRSB_SELF_HOLD:
			begin
				if (!self_req)
				begin
					state_d = SRSB_SELF_EXIT;
					cnt_d   = 4'(SRSB_SELF_CYC - 1);
				end
			end
			SRSB_SELF_EXIT:
			begin
				if (cnt_q == SRSB_CNT_RST)
				begin
					// R22 ack clears after exit
					sack_d  = 1'b0;
					ranks_d = '0;
					state_d = SRSB_IDLE;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			default:
				state_d = SRSB_IDLE;
		endcase
	end

	// R10 R15 single clock domain
	always_ff @(posedge clk_sys)
	begin
		if (rst || !urst_q[SRSB_SYNC_STAGES-1])
		begin
			state_q <= SRSB_IDLE;
			cnt_q   <= SRSB_CNT_RST;
			ack_q   <= 1'b0;
			sack_q  <= 1'b0;
			ranks_q <= '0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			ack_q   <= ack_d;
			sack_q  <= sack_d;
			ranks_q <= ranks_d;
		end
	end

	assign refresh_ack   = ack_q;
	assign self_ack      = sack_q;
	assign refresh_ranks = ranks_q;
	// R2 stall queue while refresh pending
	assign queue_hold = user_refresh.req || state_q != SRSB_IDLE;

	// R12 R14 reset synchronisers
	always_ff @(posedge clk_sys or negedge global_reset_n)
	begin
		if (!global_reset_n)
			grst_q <= '0;
		else if (clk_en)
			grst_q <= {grst_q[SRSB_SYNC_STAGES-2:0], 1'b1};
	end

	always_ff @(posedge clk_sys or negedge global_reset_n)
	begin
		if (!global_reset_n)
			urst_q <= '0;
		else if (clk_en)
			urst_q <= {urst_q[SRSB_SYNC_STAGES-2:0], pll_locked && grst_q[SRSB_SYNC_STAGES-1]};
	end
	assign user_reset_n = urst_q[SRSB_SYNC_STAGES-1];

	// R18 soft reset edge
	always_comb
	begin
		soft_d = soft_reset_n;
		phy_d  = grst_q[SRSB_SYNC_STAGES-1] && !(soft_q && !soft_reset_n);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			soft_q <= 1'b1;
			phy_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			soft_q <= soft_d;
			phy_q  <= phy_d;
		end
	end
	// R12 phy held while global low
	assign phy_reset_n = phy_q && grst_q[SRSB_SYNC_STAGES-1];

	// R17 low while unlocked
	assign reset_request_n = pll_locked;

	// R16 half-rate aux clock divider
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			half_q <= 1'b0;
		else if (clk_en)
			half_q <= !half_q;
	end
	assign aux_half_rate_clk = half_q;

	// R9 R11 ports outside block
	// R20 R21 address split
	always_comb
	begin
		addr_d = {local_addr, SRSB_RATE_DROP'(0)};
		if (ROW_FIRST)
		begin
			addr_d.bank = local_addr[SRSB_ADDR_W-1 -: SRSB_BANK_BITS];
			addr_d.row  = local_addr[SRSB_ADDR_W-SRSB_BANK_BITS-1 -: SRSB_ROW_BITS];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			mem_addr <= '0;
		else if (clk_en)
			mem_addr <= addr_d;
	end
endmodule : srsb_ctrl
`default_nettype wire

/* test/srsb_ctrl_sva.sv */
/* refresh side-band checker.
 assumes clk_en held high. */
`timescale 1ns/1ns
`default_nettype none
module srsb_ctrl_sva
	import srsb_pkg::*;
#(
	parameter int NUM_RANKS = SRSB_NUM_RANKS
)(
	// watched ports
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire logic                   pll_locked,
	input wire srsb_refresh_req_t      user_refresh,
	input wire logic                   refresh_ack,
	input wire logic [NUM_RANKS-1:0]   refresh_ranks,
	input wire logic                   self_req,
	input wire logic                   self_ack,
	input wire logic                   queue_hold,
	input wire logic [SRSB_ADDR_W-1:0] local_addr,
	input wire srsb_mem_addr_t         mem_addr,
	input wire logic                   reset_request_n,
	input wire logic                   aux_half_rate_clk
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_ack_single: assert property (refresh_ack |=> !refresh_ack)
		else $error("ack too long");
	chk_ack_cause: assert property (refresh_ack |-> $past(user_refresh.req, 5))
		else $error("ack without request");
	chk_ack_ranks: assert property (refresh_ack |->
		refresh_ranks == $past(user_refresh.chip, 5)) else $error("bad ranks");
	chk_ack_repeat: assert property (refresh_ack ##1 user_refresh.req |->
		##5 refresh_ack) else $error("held request not repeated");
	chk_hold_req: assert property (user_refresh.req |-> queue_hold)
		else $error("queue not held");
	chk_self_rise: assert property ($rose(self_ack) |-> $past(self_req, 5))
		else $error("self ack without request");
	chk_self_clear: assert property ($fell(self_req) |-> ##6 !self_ack)
		else $error("self ack stuck");
	chk_pll_req: assert property (reset_request_n == pll_locked)
		else $error("reset request wrong");
	chk_half_clk: assert property (!$past(rst) |->
		aux_half_rate_clk != $past(aux_half_rate_clk)) else $error("half clock stuck");
	chk_addr_map: assert property (!$past(rst) |->
		mem_addr == {$past(local_addr), 1'b0}) else $error("address split wrong");
endmodule : srsb_ctrl_sva
bind srsb_ctrl srsb_ctrl_sva #(.NUM_RANKS(NUM_RANKS)) u_chk (.*);
`default_nettype wire

/* test/srsb_user_model.sv */
/* user logic that asks for refresh bursts.
 assumes a one-cycle acknowledge. */
`timescale 1ns/1ns
`default_nettype none
module srsb_user_model
	import srsb_pkg::*;
(
	// control
	input wire logic          clk_sys,
	input wire logic          go,
	input wire logic [3:0]    count,
	input wire logic [3:0]    chip,
	input wire logic          refresh_ack,
	// request
	output srsb_refresh_req_t user_refresh,
	output logic [3:0]        acks
);
	always @(posedge clk_sys)
	begin
		if (!go)
			acks <= 4'h0;
		else if (refresh_ack)
			acks <= acks + 4'h1;
		user_refresh.chip <= chip;
		user_refresh.req <= go && (acks + {3'h0, refresh_ack}) < count
			&& (acks + {3'h0, refresh_ack}) < 4'(SRSB_MAX_BURST);
	end
endmodule : srsb_user_model
`default_nettype wire

/* test/srsb_ctrl_tb.sv */
/* testbench for the refresh side-band block.
 assumes 10 MHz clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module srsb_ctrl_tb
	import srsb_pkg::*;
;
	logic clk_sys = 1'b0, rst = 1'b1, glob_n = 1'b1, soft_n = 1'b1, pll = 1'b1;
	logic go = 1'b0, self_req = 1'b0, ack, self_ack, hold, urst_n, phy_n, rreq_n, half;
	logic [3:0] count = 4'h1, chip = 4'h1, ranks;
	logic [SRSB_ADDR_W-1:0] addr = '0;
	srsb_refresh_req_t ureq;
	srsb_mem_addr_t maddr;
	int num_errors = 0, num_checks = 0, nack;
	always #50 clk_sys = ~clk_sys;
	srsb_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .global_reset_n(glob_n),
		.soft_reset_n(soft_n), .pll_locked(pll), .user_refresh(ureq), .refresh_ack(ack),
		.refresh_ranks(ranks), .self_req(self_req), .self_chip(4'h1), .self_ack(self_ack),
		.queue_hold(hold), .local_addr(addr), .mem_addr(maddr), .user_reset_n(urst_n),
		.phy_reset_n(phy_n), .reset_request_n(rreq_n), .aux_half_rate_clk(half));
	srsb_user_model u_user (.clk_sys(clk_sys), .go(go), .count(count), .chip(chip),
		.refresh_ack(ack), .user_refresh(ureq), .acks());
	task automatic t_refresh(input logic [3:0] n, input logic [3:0] c, input int e);
		nack = 0;
		count = n;
		chip = c;
		go = 1'b1;
		repeat (6 * n + 4)
		begin
			@(posedge clk_sys);
			#1 nack += ack;
			if (ack) `CHK("ranks", c, ranks)
		end
		`CHK("ack count", e, nack)
		@(negedge clk_sys);
		go = 1'b0;
		repeat (2) @(negedge clk_sys);
		$display("done refresh");
	endtask : t_refresh
	task automatic t_other;
		self_req = 1'b1;
		addr = 24'hABCDEF;
		@(negedge clk_sys);
		`CHK("row", 13'h1579, maddr.row)
		repeat (5) @(negedge clk_sys);
		`CHK("self ack", 1'b1, self_ack)
		self_req = 1'b0;
		repeat (7) @(negedge clk_sys);
		`CHK("self ack", 1'b0, self_ack)
		pll = 1'b0;
		glob_n = 1'b0;
		soft_n = 1'b0;
		#1 `CHK("reset request", 1'b0, rreq_n)
		`CHK("user reset", 1'b0, urst_n)
		@(negedge clk_sys);
		pll = 1'b1;
		glob_n = 1'b1;
		soft_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		`CHK("user reset", 1'b1, urst_n)
		`CHK("phy reset", 1'b1, phy_n)
		soft_n = 1'b0;
		@(negedge clk_sys);
		`CHK("phy reset", 1'b0, phy_n)
		@(negedge clk_sys);
		`CHK("phy reset", 1'b1, phy_n)
		soft_n = 1'b1;
		$display("done other");
	endtask : t_other
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		t_refresh(4'h1, 4'h1, 1);
		t_refresh(4'h2, 4'h5, 2);
		t_refresh(4'h9, 4'hF, 9);
		t_refresh(4'h3, 4'h0, 0);
		t_other;
		print_verdict;
	end
	// about 150 cycles expected, 3000 allowed
	initial
	begin
		#300000;
		num_errors++;
		print_verdict;
	end
endmodule : srsb_ctrl_tb
`default_nettype wire
